// file: src/eeprom_consts.svh
// Constants for the two-wire serial memory target: sizes, address pattern, timing.
// Assumes it is included by the package and the design file, nothing else.
// Operation
// - Sample data on clock rise, drive on fall
// - Data line is open-drain only
// - Two select pins set address, floating low
// - Protect pin high makes array read-only
// - Array is 512 bytes, 9-bit address
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Eight-bit words, acknowledge on ninth clock
// - Address word: 1010, select pins, page bit
// - Eighth address bit selects read or write
// - Acknowledge match, else silent until next start
// - Byte write: address, word address, data, stop
// - Stop after write starts silent programming cycle
// - Page write takes up to sixteen bytes
// - Write increments only low four address bits
// - Busy device ignores address word; controller polls
// - Counter keeps last address plus one
// - Reads wrap across the whole array
// - Current read sends byte at counter address; the code replaces counter bit 8 with the page bit of the address word
// - Controller acknowledge continues sequential read
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define DATA_W 8
`define ADDR_W 9
`define MEM_WORDS 512
`define DEV_CODE 4'hA
`define BITS_PER_WORD 4'h8
`define FIFO_DEPTH 8
`define PROG_TIME_NS 5000000
`define CLK_PERIOD_NS 100
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define PROG_CNT_W 16
`endif

// file: src/eeprom_pkg.sv
// Types shared by the two-wire serial memory target.
// Assumes eeprom_consts.svh is on the include path.
`include "eeprom_consts.svh"
package eeprom_pkg;
	typedef enum logic [2:0] {S_IDLE, S_RECV, S_ACK, S_SEND, S_MACK, S_WAIT} busState_e;
	typedef enum logic [1:0] {K_DEV, K_WORD, K_DATA} byteKind_e;
	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
	} wrEntry_s;
	typedef struct packed {
		logic                              scl1, scl2, sclPrev;
		logic                              sda1, sda2, sdaPrev;
		logic [1:0]                        sel1, sel2;
		logic                              wp1, wp2;
		busState_e                         state;
		byteKind_e                         kind;
		logic [3:0]                        bitCnt;
		logic [`DATA_W-1:0]                shift;
		logic                              pageBit;
		logic                              isRead;
		logic                              ackOk;
		logic                              wrPending;
		logic [`ADDR_W-1:0]                addr;
		logic                              busy;
		logic [`PROG_CNT_W-1:0]            progCnt;
		logic                              sdaOe;
		logic                              sdaOut;
		logic [`MEM_WORDS-1:0][`DATA_W-1:0] mem;
	} core_s;
endpackage

// file: src/serial_eeprom_two_wire_target.sv
// Two-wire serial memory target and its write-entry FIFO.
// Assumes clk at 10 MHz, synchronous active-high srst, and an external wired-AND
// resolution of the data line from sdaOe; the link clock is sampled, not used as a clock.
`include "eeprom_consts.svh"

// ****************************************************************
// Write-entry FIFO
// ****************************************************************
module byte_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slot;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [PW:0]                 count;
	} fifoState_s;
	fifoState_s q, d;
	logic       doPush, doPop;

	assign inReady  = (q.count != (PW+1)'(DEPTH));
	assign outValid = (q.count != '0);
	assign outData  = q.slot[q.rp];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// Depth is taken as a power of two so the pointers wrap by themselves
	always_comb
	begin
		d = q;
		if (doPush)
		begin
			d.slot[q.wp] = inData;
			d.wp = q.wp + PW'(1);
		end
		if (doPop)
			d.rp = q.rp + PW'(1);
		if (doPush && !doPop)
			d.count = q.count + (PW+1)'(1);
		else if (doPop && !doPush)
			d.count = q.count - (PW+1)'(1);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			q <= '0;
		else
			q <= d;
	end
endmodule // byte_fifo

// ****************************************************************
// Target top
// ****************************************************************
module serial_eeprom_two_wire_target #(
	parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic sclIn,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	input  wire logic busSelectPinLow,
	input  wire logic busSelectPinHigh,
	input  wire logic writeProtect,
	output logic      programBusy
);
	localparam logic [`PROG_CNT_W-1:0] PROG_LAST = `PROG_CNT_W'(PROG_CYCLES - 1);

	eeprom_pkg::core_s    q, d;
	eeprom_pkg::wrEntry_s pushEntry, popEntry;
	logic                 sclRise, sclFall, startC, stopC;
	logic                 evalNow, devMatch, loadNow;
	logic                 fifoPush, fifoInReady, fifoOutValid, fifoOutReady;

	// ****************************************************************
	// Edge and condition detection
	// ****************************************************************
	// Only the second and third stages are looked at; the first may be metastable
	assign sclRise = q.scl2 && !q.sclPrev;
	assign sclFall = !q.scl2 && q.sclPrev;
	assign startC  = q.scl2 && q.sclPrev && !q.sda2 && q.sdaPrev;
	assign stopC   = q.scl2 && q.sclPrev && q.sda2 && !q.sdaPrev;
	assign evalNow = sclFall && (q.state == eeprom_pkg::S_RECV)
		&& (q.bitCnt == `BITS_PER_WORD);
	// Floating select pins are pulled low at the board; here they are plain levels
	assign devMatch = (q.shift[7:4] == `DEV_CODE) && (q.shift[3] == q.sel2[1])
		&& (q.shift[2] == q.sel2[0]);
	assign loadNow = !q.busy && !startC && !stopC && sclFall
		&& (((q.state == eeprom_pkg::S_ACK) && q.isRead && (q.kind == eeprom_pkg::K_DEV))
		|| ((q.state == eeprom_pkg::S_MACK) && q.ackOk));

	// ****************************************************************
	// Write path buffer
	// ****************************************************************
	// The array has one port; a read fetch wins and the commit waits a cycle
	assign fifoOutReady = !loadNow;
	assign fifoPush     = evalNow && !q.busy && (q.kind == eeprom_pkg::K_DATA)
		&& !q.wp2 && fifoInReady;
	assign pushEntry.addr = q.addr;
	assign pushEntry.data = q.shift;

	byte_fifo #(
		.WIDTH ($bits(eeprom_pkg::wrEntry_s)),
		.DEPTH (`FIFO_DEPTH)
	) writeBuf (
		.clk      (clk),
		.srst     (srst),
		.inData   (pushEntry),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.outData  (popEntry),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		d = q;
		d.scl1    = sclIn;
		d.scl2    = q.scl1;
		d.sclPrev = q.scl2;
		d.sda1    = sdaIn;
		d.sda2    = q.sda1;
		d.sdaPrev = q.sda2;
		d.sel1    = {busSelectPinHigh, busSelectPinLow};
		d.sel2    = q.sel1;
		d.wp1     = writeProtect;
		d.wp2     = q.wp1;
		d.sdaOut  = 1'b0;
		if (fifoOutValid && fifoOutReady)
			d.mem[popEntry.addr] = popEntry.data;
		if (q.busy)
		begin
			// Bus is deaf while programming; polls get no acknowledge
			d.sdaOe = 1'b0;
			if (q.progCnt == PROG_LAST)
			begin
				d.busy    = 1'b0;
				d.progCnt = '0;
			end
			else
				d.progCnt = q.progCnt + `PROG_CNT_W'(1);
		end
		else if (startC)
		begin
			d.state  = eeprom_pkg::S_RECV;
			d.kind   = eeprom_pkg::K_DEV;
			d.bitCnt = '0;
			d.sdaOe  = 1'b0;
			d.ackOk  = 1'b0;
		end
		else if (stopC)
		begin
			d.state  = eeprom_pkg::S_IDLE;
			d.sdaOe  = 1'b0;
			d.ackOk  = 1'b0;
			if (q.wrPending)
			begin
				d.busy      = 1'b1;
				d.progCnt   = '0;
				d.wrPending = 1'b0;
			end
		end
		else
		begin
			case (q.state)
				eeprom_pkg::S_RECV:
				begin
					if (sclRise && (q.bitCnt != `BITS_PER_WORD))
					begin
						d.shift  = {q.shift[6:0], q.sda2};
						d.bitCnt = q.bitCnt + 4'h1;
					end
					else if (evalNow)
					begin
						case (q.kind)
							eeprom_pkg::K_DEV:
							begin
								if (devMatch)
								begin
									d.pageBit = q.shift[1];
									d.isRead  = q.shift[0];
									if (q.shift[0])
										d.addr[8] = q.shift[1];
									d.sdaOe = 1'b1;
									d.state = eeprom_pkg::S_ACK;
								end
								else
									d.state = eeprom_pkg::S_WAIT;
							end
							eeprom_pkg::K_WORD:
							begin
								d.addr  = {q.pageBit, q.shift};
								d.sdaOe = 1'b1;
								d.state = eeprom_pkg::S_ACK;
							end
							default:
							begin
								if (q.wp2 || fifoInReady)
								begin
									// Protected bytes are acknowledged and dropped
									d.wrPending = q.wrPending || !q.wp2;
									d.addr[3:0] = q.addr[3:0] + 4'h1;
									d.sdaOe     = 1'b1;
									d.state     = eeprom_pkg::S_ACK;
								end
								// A full buffer refuses the byte: no acknowledge, silent until start
								else
									d.state = eeprom_pkg::S_WAIT;
							end
						endcase
					end
				end
				eeprom_pkg::S_ACK:
				begin
					if (sclFall)
					begin
						d.sdaOe  = 1'b0;
						d.bitCnt = '0;
						if (!(q.isRead && (q.kind == eeprom_pkg::K_DEV)))
						begin
							d.state = eeprom_pkg::S_RECV;
							d.kind  = (q.kind == eeprom_pkg::K_DEV) ? eeprom_pkg::K_WORD
								: eeprom_pkg::K_DATA;
						end
					end
				end
				eeprom_pkg::S_SEND:
				begin
					if (sclFall)
					begin
						if (q.bitCnt == `BITS_PER_WORD)
						begin
							d.sdaOe = 1'b0;
							d.state = eeprom_pkg::S_MACK;
						end
						else
						begin
							d.sdaOe  = !q.shift[6];
							d.shift  = {q.shift[6:0], 1'b0};
							d.bitCnt = q.bitCnt + 4'h1;
						end
					end
				end
				eeprom_pkg::S_MACK:
				begin
					if (sclRise)
					begin
						if (!q.sda2)
							d.ackOk = 1'b1;
						else
							d.state = eeprom_pkg::S_WAIT;
					end
				end
				eeprom_pkg::S_IDLE, eeprom_pkg::S_WAIT:
					d.sdaOe = 1'b0;
				default:
					d.state = eeprom_pkg::S_IDLE;
			endcase
		end
		if (loadNow)
		begin
			d.shift  = q.mem[q.addr];
			d.addr   = q.addr + 9'h001;
			d.sdaOe  = !q.mem[q.addr][7];
			d.bitCnt = 4'h1;
			d.ackOk  = 1'b0;
			d.state  = eeprom_pkg::S_SEND;
		end
	end

	// Link synchronisers wake at the idle-high bus level, so no false edge follows reset
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			q         <= '0;
			q.scl1    <= 1'b1;
			q.scl2    <= 1'b1;
			q.sclPrev <= 1'b1;
			q.sda1    <= 1'b1;
			q.sda2    <= 1'b1;
			q.sdaPrev <= 1'b1;
		end
		else
			q <= d;
	end

	assign sdaOut      = q.sdaOut;
	assign sdaOe       = q.sdaOe;
	assign programBusy = q.busy;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	addr_ack_a: assert property (
		evalNow && (q.kind == eeprom_pkg::K_DEV) && devMatch && !q.busy
		|=> q.sdaOe && (q.state == eeprom_pkg::S_ACK))
		else $error("matching address word not acknowledged");
	addr_quiet_a: assert property (
		evalNow && (q.kind == eeprom_pkg::K_DEV) && !devMatch && !q.busy
		|=> (!q.sdaOe && (q.state == eeprom_pkg::S_WAIT)) [*8])
		else $error("mismatched address word got a response");
	busy_silent_a: assert property (
		q.busy |-> !q.sdaOe && (q.state == eeprom_pkg::S_IDLE))
		else $error("data line driven during programming");
	prog_start_a: assert property (
		!q.busy && stopC && q.wrPending |=> q.busy && (q.progCnt == '0))
		else $error("stop after write did not start programming");
	prog_end_a: assert property (
		$fell(q.busy) |-> $past(q.progCnt) == PROG_LAST)
		else $error("programming ended before the counter expired");
	protect_drop_a: assert property (
		evalNow && !q.busy && (q.kind == eeprom_pkg::K_DATA) && q.wp2
		|-> !fifoPush ##1 q.sdaOe)
		else $error("protected byte written or not acknowledged");
	page_wrap_a: assert property (
		fifoPush |=> (q.addr[8:4] == $past(q.addr[8:4]))
		&& (q.addr[3:0] == $past(q.addr[3:0]) + 4'h1))
		else $error("write address left its page");
	read_step_a: assert property (
		loadNow |=> (q.addr == $past(q.addr) + 9'h001) && (q.state == eeprom_pkg::S_SEND))
		else $error("read did not advance the address counter");
	drive_edge_a: assert property (
		$rose(q.sdaOe) |-> $past(sclFall))
		else $error("data line pulled low outside a clock fall");
	open_drain_a: assert property (
		!sdaOut)
		else $error("data line driven high");
	nack_release_a: assert property (
		(q.state == eeprom_pkg::S_MACK) && sclRise && q.sda2 && !startC && !stopC
		|=> !q.sdaOe && (q.state == eeprom_pkg::S_WAIT))
		else $error("device kept sending after no-acknowledge");

	// Start and stop take over from whatever the byte engine was doing
	start_enter_a: assert property (
		!q.busy && startC
		|=> (q.state == eeprom_pkg::S_RECV) && (q.kind == eeprom_pkg::K_DEV)
		&& (q.bitCnt == 4'h0) && !q.sdaOe)
		else $error("start did not restart address reception");
	stop_idle_a: assert property (
		!q.busy && stopC |=> (q.state == eeprom_pkg::S_IDLE) && !q.sdaOe)
		else $error("stop did not return the target to standby");
	ack_release_a: assert property (
		(q.state == eeprom_pkg::S_ACK) && sclFall && !q.busy
		|=> !q.sdaOe || (q.state == eeprom_pkg::S_SEND))
		else $error("acknowledge held past its clock");
	wait_quiet_a: assert property (
		(q.state == eeprom_pkg::S_WAIT) |=> !q.sdaOe)
		else $error("data line driven while waiting for start or stop");

	read_byte_c: cover property (loadNow ##[1:1000] (q.state == eeprom_pkg::S_MACK));
	prog_cycle_c: cover property ($rose(q.busy));
	seq_read_c: cover property ((q.state == eeprom_pkg::S_MACK) && q.ackOk ##[1:20] loadNow);
	protect_c: cover property (evalNow && (q.kind == eeprom_pkg::K_DATA) && q.wp2);
endmodule // serial_eeprom_two_wire_target

// file: tb/bus_controller_model.sv
// Controller on the far side of the two-wire memory target: start, stop, byte transfers.
// Assumes the bench resolves the data line (pull-up, wired-AND) and feeds it back here.
module bus_controller_model (
	input  wire logic       clk,
	input  wire logic       sdaLine,
	output logic            scl,
	output logic            sdaDrv,
	output logic      [8:0] rxWord,
	output logic            rxStrobe
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		scl = 1'b1; // Clock stands high between frames
		sdaDrv = 1'b1;
		rxWord = '0;
		rxStrobe = 1'b0;
	end

	// Quarter of an 800 ns bus period, moves only on the falling system edge
	task automatic quarter();
		repeat (2) @(negedge clk);
	endtask

	task automatic startCond();
		sdaDrv = 1'b1;
		quarter();
		scl = 1'b1;
		quarter();
		sdaDrv = 1'b0; // Data falls with clock high
		quarter();
		scl = 1'b0;
		quarter();
	endtask

	task automatic stopCond();
		sdaDrv = 1'b0;
		quarter();
		scl = 1'b1;
		quarter();
		sdaDrv = 1'b1; // Data rises with clock high
		quarter();
	endtask

	task automatic bitXfer(input logic b, output logic r);
		sdaDrv = b; // Data moves only while clock is low
		quarter();
		scl = 1'b1;
		quarter();
		r = sdaLine; // Mid-high sample leaves margin after the target's update
		quarter();
		scl = 1'b0;
		quarter();
	endtask

	// Eight bits MSB first, then the acknowledge clock
	task automatic byteXfer(input logic [7:0] tx, input logic ackTx);
		logic [8:0] v;
		logic [8:0] r;
		v = {tx, ackTx};
		for (int i = 8; i >= 0; i--)
			bitXfer(v[i], r[i]);
		rxWord = r;
		rxStrobe = 1'b1;
		@(negedge clk);
		rxStrobe = 1'b0;
	endtask
endmodule // bus_controller_model

// file: tb/serial_eeprom_two_wire_target_bench.sv
// Self-checking bench for the two-wire serial memory target.
// Assumes bus_controller_model drives the bus; programming shortened to 20 cycles.
`define CHK(got, exp, msg) \
	begin \
		nChecks++; \
		if ((got) !== (exp)) \
		begin \
			nFail++; \
			$display("mismatch at %0t: %s", $time, msg); \
		end \
	end

module serial_eeprom_two_wire_target_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned PROG = 20;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        selLow = 1'b0;
	logic        selHigh = 1'b0;
	logic        wp = 1'b0;
	logic        scl, sdaDrv, sdaLine, sdaOut, sdaOe, programBusy, rxStrobe;
	logic [8:0]  rxWord;
	logic [17:0] expQ[$];
	logic [7:0]  d[16];
	logic [7:0]  e0, e1;
	logic [31:0] lfsr = 32'h9257;
	int          nFail = 0;
	int          nChecks = 0;
	int          cycles = 0;

	// ****************************************************************
	// Harness
	// ****************************************************************
	always #50 clk = ~clk;
	assign sdaLine = sdaDrv & !(sdaOe && !sdaOut); // Pull-up, target only pulls low

	serial_eeprom_two_wire_target #(.PROG_CYCLES(PROG)) i_dut (
		.clk(clk), .srst(srst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .busSelectPinLow(selLow), .busSelectPinHigh(selHigh),
		.writeProtect(wp), .programBusy(programBusy));

	bus_controller_model i_ctl (
		.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv),
		.rxWord(rxWord), .rxStrobe(rxStrobe));

	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] dev(input logic pg, input logic rd);
		return {4'hA, selHigh, selLow, pg, rd};
	endfunction

	// Note the masked {data, ack} expectation, then run the byte
	task automatic put(input logic [7:0] tx, input logic ackTx, input logic [8:0] mask,
		input logic [8:0] exp);
		expQ.push_back({mask, exp});
		i_ctl.byteXfer(tx, ackTx);
	endtask

	task automatic busyCheck(input logic expHigh);
		repeat (8) @(negedge clk);
		`CHK(programBusy, expHigh, "busy after stop")
		repeat (PROG - 9) @(negedge clk);
		`CHK(programBusy, expHigh, "busy ended early")
		repeat (3) @(negedge clk);
		`CHK(programBusy, 1'b0, "busy past count")
	endtask

	task automatic printVerdict();
		$display("checks %0d, mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************************************
	// Watcher and limit
	// ****************************************************************
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			nFail++;
			printVerdict();
		end
		else if (rxStrobe === 1'b1)
		begin
			`CHK(expQ.size() > 0, 1'b1, "word without note")
			`CHK(rxWord & expQ[0][17:9], expQ[0][8:0], "bus word")
			void'(expQ.pop_front());
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial
	begin
		lfsr = lfsrNext(lfsr);
		{selHigh, selLow} = lfsr[1:0];
		for (int k = 0; k < 18; k++)
		begin
			lfsr = lfsrNext(lfsr);
			if (k < 16)
				d[k] = lfsr[7:0];
		end
		e0 = lfsr[15:8];
		e1 = lfsr[23:16];
		repeat (12) @(negedge clk);
		`CHK({sdaOe, programBusy}, 2'b00, "reset state")
		srst = 1'b0;
		repeat (8) @(negedge clk);
		// Foreign select code stays silent
		i_ctl.startCond();
		put({4'hA, ~selHigh, selLow, 2'b00}, 1'b1, 9'h001, 9'h001);
		i_ctl.stopCond();
		// Full page from 0xF5 of page one, wraps inside the page
		i_ctl.startCond();
		put(dev(1'b1, 1'b0), 1'b1, 9'h001, 9'h000);
		put(8'hF5, 1'b1, 9'h001, 9'h000);
		for (int k = 0; k < 16; k++)
			put(d[k], 1'b1, 9'h001, 9'h000);
		i_ctl.stopCond();
		// Poll lands inside the programming cycle: refused
		i_ctl.startCond();
		put(dev(1'b0, 1'b0), 1'b1, 9'h001, 9'h001);
		i_ctl.stopCond();
		i_ctl.startCond();
		put(dev(1'b0, 1'b0), 1'b1, 9'h001, 9'h000);
		put(8'h00, 1'b1, 9'h001, 9'h000);
		put(e0, 1'b1, 9'h001, 9'h000);
		put(e1, 1'b1, 9'h001, 9'h000);
		i_ctl.stopCond();
		busyCheck(1'b1);
		// Protected write is acknowledged but leaves the array alone
		wp = 1'b1;
		i_ctl.startCond();
		put(dev(1'b0, 1'b0), 1'b1, 9'h001, 9'h000);
		put(8'h00, 1'b1, 9'h001, 9'h000);
		put(~e0, 1'b1, 9'h001, 9'h000);
		i_ctl.stopCond();
		busyCheck(1'b0);
		// Counter sits one past the dropped byte, so the byte after it comes back
		i_ctl.startCond();
		put(dev(1'b0, 1'b1), 1'b1, 9'h001, 9'h000);
		put(8'hFF, 1'b1, 9'h1FE, {e1, 1'b0});
		i_ctl.stopCond();
		wp = 1'b0;
		// Random read of 0x1F0, sequential across the array end
		i_ctl.startCond();
		put(dev(1'b1, 1'b0), 1'b1, 9'h001, 9'h000);
		put(8'hF0, 1'b1, 9'h001, 9'h000);
		i_ctl.startCond();
		put(dev(1'b1, 1'b1), 1'b1, 9'h001, 9'h000);
		for (int j = 0; j < 16; j++)
			put(8'hFF, 1'b0, 9'h1FE, {d[(j + 11) % 16], 1'b0});
		put(8'hFF, 1'b1, 9'h1FE, {e0, 1'b0});
		i_ctl.stopCond();
		// Current-address read picks up after the last byte read
		i_ctl.startCond();
		put(dev(1'b0, 1'b1), 1'b1, 9'h001, 9'h000);
		put(8'hFF, 1'b1, 9'h1FE, {e1, 1'b0});
		`CHK(sdaOe, 1'b0, "line held after no-ack")
		i_ctl.stopCond();
		repeat (4) @(negedge clk);
		`CHK(expQ.size() == 0, 1'b1, "notes left over")
		printVerdict();
	end
endmodule // serial_eeprom_two_wire_target_bench
